// ===== core/agc_time_select.sv
// register bank selecting left agc decay and right agc attack time constants
// ---------------------------------------------------------------
// Notes on behaviour
// - left decay comes from legacy input when select bit is 0, else register.
// - decay baseline codes 0..3 give 50, 150, 250, 350 ms.
// - decay multiplier code n scales baseline by two to the n.
// - decay capped at 4, 5.6, 8, 9.6 s for ratios 1 to 2.5.
// - cap 11.2 s at 3/3.5, 16 s at 4/4.5, 19.2 s, 22.4 s.
// - right attack comes from legacy input when select bit is 0, else register.
// - attack baseline codes 0..3 give 7, 8, 10, 11 ms.
// - attack multiplier code n scales baseline by two to the n.
// - after reset both registers read zero, legacy timing in force.
// ---------------------------------------------------------------
module agc_time_select
(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  // register port
  input wire agc_tc_pkg::reg_req_t REG_REQ,
  output logic [7:0] REG_RD_DATA,
  output logic REG_RD_VALID,
  // codec clocking and legacy settings
  input wire logic [3:0] CODEC_CLOCK_RATIO,
  input wire logic [15:0] LEGACY_LEFT_DECAY_MS,
  input wire logic [15:0] LEGACY_RIGHT_ATTACK_MS,
  // effective time constants
  output agc_tc_pkg::agc_time_t LEFT_DECAY,
  output agc_tc_pkg::agc_time_t RIGHT_ATTACK
);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  agc_tc_pkg::time_reg_t decay_reg_ff;
  agc_tc_pkg::time_reg_t nxt_decay_reg;
  agc_tc_pkg::time_reg_t attack_reg_ff;
  agc_tc_pkg::time_reg_t nxt_attack_reg;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic rd_valid_ff;
  agc_tc_pkg::agc_time_t left_decay_ff;
  agc_tc_pkg::agc_time_t right_attack_ff;

  wire logic hit_decay;
  wire logic hit_attack;
  wire logic wr_decay;
  wire logic wr_attack;

  assign hit_decay = REG_REQ.addr == agc_tc_pkg::LEFT_DECAY_OFS;
  assign hit_attack = REG_REQ.addr == agc_tc_pkg::RIGHT_ATTACK_OFS;
  assign wr_decay = REG_REQ.wr && hit_decay;
  assign wr_attack = REG_REQ.wr && hit_attack;

  // reserved low bits are stored as written; software is expected to keep them zero
  assign nxt_decay_reg = wr_decay ? agc_tc_pkg::time_reg_t'(REG_REQ.wdata) : decay_reg_ff;
  assign nxt_attack_reg = wr_attack ? agc_tc_pkg::time_reg_t'(REG_REQ.wdata) : attack_reg_ff;

  // a read returns the value held before a write in the same cycle
  assign nxt_rd_data = hit_decay ? 8'(decay_reg_ff) :
                       hit_attack ? 8'(attack_reg_ff) :
                       agc_tc_pkg::UNMAPPED_RD;

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      decay_reg_ff <= agc_tc_pkg::time_reg_t'(agc_tc_pkg::TIME_REG_RST);
      attack_reg_ff <= agc_tc_pkg::time_reg_t'(agc_tc_pkg::TIME_REG_RST);
    end
    else if (CE)
    begin
      decay_reg_ff <= nxt_decay_reg;
      attack_reg_ff <= nxt_attack_reg;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      rd_data_ff <= agc_tc_pkg::UNMAPPED_RD;
      rd_valid_ff <= 1'b0;
    end
    else if (CE)
    begin
      rd_data_ff <= REG_REQ.rd ? nxt_rd_data : rd_data_ff;
      rd_valid_ff <= REG_REQ.rd;
    end
  end

  assign REG_RD_DATA = rd_data_ff;
  assign REG_RD_VALID = rd_valid_ff;

  // ---------------------------------------------------------------
  // time channels: 0 = left decay, 1 = right attack
  // ---------------------------------------------------------------
  agc_tc_pkg::time_reg_t chan_field [2];
  logic [15:0] chan_base [2];
  logic [15:0] chan_legacy [2];
  logic chan_cap_en [2];
  agc_tc_pkg::agc_time_t chan_result [2];
  wire logic [15:0] cap_ms;

  assign cap_ms = agc_tc_pkg::decay_cap(CODEC_CLOCK_RATIO);

  assign chan_field[0] = decay_reg_ff;
  assign chan_base[0] = agc_tc_pkg::decay_base(decay_reg_ff.base);
  assign chan_legacy[0] = LEGACY_LEFT_DECAY_MS;
  // only decay is bounded by the codec clock ratio; attack times stay short
  assign chan_cap_en[0] = 1'b1;
  assign chan_field[1] = attack_reg_ff;
  assign chan_base[1] = agc_tc_pkg::attack_base(attack_reg_ff.base);
  assign chan_legacy[1] = LEGACY_RIGHT_ATTACK_MS;
  assign chan_cap_en[1] = 1'b0;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      agc_time_scale u_scale
      (
        .field(chan_field[ch]),
        .base_ms(chan_base[ch]),
        .legacy_ms(chan_legacy[ch]),
        .cap_en(chan_cap_en[ch]),
        .cap_ms(cap_ms),
        .result(chan_result[ch])
      );
    end
  endgenerate

  // outputs are registered so the gain loop sees a clean value per cycle
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      left_decay_ff <= '0;
      right_attack_ff <= '0;
    end
    else if (CE)
    begin
      left_decay_ff <= chan_result[0];
      right_attack_ff <= chan_result[1];
    end
  end

  assign LEFT_DECAY = left_decay_ff;
  assign RIGHT_ATTACK = right_attack_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // a write to the decay register followed by a quiet enabled cycle
  sequence s_decay_write;
    CE && wr_decay;
  endsequence

  sequence s_quiet_step;
    CE && !wr_decay && !wr_attack;
  endsequence

  sequence s_attack_write;
    CE && wr_attack;
  endsequence

  // decay override at its largest product, so every ratio ceiling must cut it
  sequence s_decay_at_max;
    CE && decay_reg_ff.sel && decay_reg_ff.base == 2'h3 && decay_reg_ff.mult == 3'h7;
  endsequence

  chk_decay_legacy_path: assert property (
    (CE && !decay_reg_ff.sel) |=>
      (LEFT_DECAY.ms == $past(LEGACY_LEFT_DECAY_MS)) && !LEFT_DECAY.from_override)
  else $error("left decay did not follow legacy setting");

  chk_decay_override_base: assert property (
    (CE && decay_reg_ff.sel && decay_reg_ff.mult == 3'h0) |=>
      LEFT_DECAY.ms == agc_tc_pkg::decay_base($past(decay_reg_ff.base)))
  else $error("left decay baseline wrong at factor one");

  chk_decay_factor_step: assert property (
    (CE && decay_reg_ff.sel && decay_reg_ff.base == 2'h0 && decay_reg_ff.mult == 3'h3) |=>
      (LEFT_DECAY.ms == 16'h0190))
  else $error("decay of 50 ms times 8 is not 400 ms");

  chk_decay_cap_low: assert property (
    (CE && decay_reg_ff.sel && decay_reg_ff.base == 2'h3 && decay_reg_ff.mult == 3'h7
      && CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_1P0) |=>
      (LEFT_DECAY.ms == 16'h0fa0) && LEFT_DECAY.capped)
  else $error("decay not limited to 4 s at ratio 1");

  chk_decay_cap_high: assert property (
    (CE && decay_reg_ff.sel && decay_reg_ff.base == 2'h3 && decay_reg_ff.mult == 3'h7
      && CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_4P5) |=>
      (LEFT_DECAY.ms == 16'h3e80) && LEFT_DECAY.capped)
  else $error("decay not limited to 16 s at ratio 4.5");

  chk_decay_never_over: assert property (
    (CE && decay_reg_ff.sel) |=>
      LEFT_DECAY.ms <= agc_tc_pkg::decay_cap($past(CODEC_CLOCK_RATIO)))
  else $error("override decay exceeds ratio ceiling");

  chk_attack_legacy_path: assert property (
    (CE && !attack_reg_ff.sel) |=>
      (RIGHT_ATTACK.ms == $past(LEGACY_RIGHT_ATTACK_MS)) && !RIGHT_ATTACK.from_override)
  else $error("right attack did not follow legacy setting");

  chk_attack_base_factor: assert property (
    (CE && attack_reg_ff.sel && attack_reg_ff.base == 2'h2 && attack_reg_ff.mult == 3'h1) |=>
      RIGHT_ATTACK.ms == 16'h0014)
  else $error("attack of 10 ms times 2 is not 20 ms");

  chk_attack_top_factor: assert property (
    (CE && attack_reg_ff.sel && attack_reg_ff.mult == 3'h7) |=>
      (RIGHT_ATTACK.ms == ($past(chan_base[1]) << 7)) && !RIGHT_ATTACK.capped)
  else $error("attack factor 128 wrong or capped");

  chk_decay_write_takes: assert property (
    s_decay_write ##1 s_quiet_step |=>
      LEFT_DECAY.from_override == $past(REG_REQ.wdata[agc_tc_pkg::SEL_POS], 2))
  else $error("decay select write not seen two cycles later");

  chk_attack_write_takes: assert property (
    s_attack_write ##1 s_quiet_step |=>
      RIGHT_ATTACK.from_override == $past(REG_REQ.wdata[agc_tc_pkg::SEL_POS], 2))
  else $error("attack select write not seen two cycles later");

  chk_reset_reads_zero: assert property (
    $rose(RST_B) |-> (decay_reg_ff == '0) && (attack_reg_ff == '0) && !LEFT_DECAY.from_override)
  else $error("time registers not zero after reset");

  chk_read_back: assert property (
    (CE && REG_REQ.rd && hit_decay) |=> REG_RD_VALID && (REG_RD_DATA == 8'($past(decay_reg_ff))))
  else $error("decay register read back wrong");

  chk_freeze_on_ce: assert property (
    !CE |=> $stable(LEFT_DECAY) && $stable(RIGHT_ATTACK) && $stable(REG_RD_VALID))
  else $error("state moved while clock enable low");

  chk_regs_frozen: assert property (
    !CE |=> $stable(decay_reg_ff) && $stable(attack_reg_ff) && $stable(REG_RD_DATA))
  else $error("register moved while clock enable low");

  chk_reset_clears_outputs: assert property (
    $rose(RST_B) |-> (LEFT_DECAY == '0) && (RIGHT_ATTACK == '0) && !REG_RD_VALID)
  else $error("time outputs not zero after reset");

  chk_read_valid_pulse: assert property (
    (CE && !REG_REQ.rd) |=> !REG_RD_VALID)
  else $error("read answer stood longer than one cycle");

  chk_unmapped_read_zero: assert property (
    (CE && REG_REQ.rd && !hit_decay && !hit_attack) |=>
      REG_RD_VALID && (REG_RD_DATA == 8'h00))
  else $error("unmapped register did not read zero");

  chk_attack_read_back: assert property (
    (CE && REG_REQ.rd && hit_attack) |=>
      REG_RD_VALID && (REG_RD_DATA == 8'($past(attack_reg_ff))))
  else $error("attack register read back wrong");

  chk_decay_source_flag: assert property (
    CE |=> LEFT_DECAY.from_override == $past(decay_reg_ff.sel))
  else $error("left decay source flag disagrees with select bit");

  chk_attack_source_flag: assert property (
    CE |=> RIGHT_ATTACK.from_override == $past(attack_reg_ff.sel))
  else $error("right attack source flag disagrees with select bit");

  // the ceiling belongs to the override path only; legacy values pass untouched
  chk_legacy_not_capped: assert property (
    (CE && !decay_reg_ff.sel) |=> !LEFT_DECAY.capped)
  else $error("legacy decay was flagged as capped");

  chk_attack_top_value: assert property (
    (CE && attack_reg_ff.sel && attack_reg_ff.base == 2'h3 && attack_reg_ff.mult == 3'h7) |=>
      (RIGHT_ATTACK.ms == 16'h0580) && !RIGHT_ATTACK.capped)
  else $error("attack of 11 ms times 128 is not 1408 ms");

  chk_decay_cap_1p5: assert property (
    s_decay_at_max ##0 (CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_1P5) |=>
      (LEFT_DECAY.ms == 16'h15e0) && LEFT_DECAY.capped)
  else $error("decay not limited to 5.6 s at ratio 1.5");

  chk_decay_cap_2p0: assert property (
    s_decay_at_max ##0 (CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_2P0) |=>
      (LEFT_DECAY.ms == 16'h1f40) && LEFT_DECAY.capped)
  else $error("decay not limited to 8 s at ratio 2");

  chk_decay_cap_2p5: assert property (
    s_decay_at_max ##0 (CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_2P5) |=>
      (LEFT_DECAY.ms == 16'h2580) && LEFT_DECAY.capped)
  else $error("decay not limited to 9.6 s at ratio 2.5");

  chk_decay_cap_3p0: assert property (
    s_decay_at_max ##0 (CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_3P0) |=>
      (LEFT_DECAY.ms == 16'h2bc0) && LEFT_DECAY.capped)
  else $error("decay not limited to 11.2 s at ratio 3");

  chk_decay_cap_3p5: assert property (
    s_decay_at_max ##0 (CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_3P5) |=>
      (LEFT_DECAY.ms == 16'h2bc0) && LEFT_DECAY.capped)
  else $error("decay not limited to 11.2 s at ratio 3.5");

  chk_decay_cap_4p0: assert property (
    s_decay_at_max ##0 (CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_4P0) |=>
      (LEFT_DECAY.ms == 16'h3e80) && LEFT_DECAY.capped)
  else $error("decay not limited to 16 s at ratio 4");

  chk_decay_cap_5p0: assert property (
    s_decay_at_max ##0 (CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_5P0) |=>
      (LEFT_DECAY.ms == 16'h4b00) && LEFT_DECAY.capped)
  else $error("decay not limited to 19.2 s at ratio 5");

  chk_decay_cap_5p5: assert property (
    s_decay_at_max ##0 (CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_5P5) |=>
      (LEFT_DECAY.ms == 16'h5780) && LEFT_DECAY.capped)
  else $error("decay not limited to 22.4 s at ratio 5.5");

  chk_decay_cap_6p0: assert property (
    s_decay_at_max ##0 (CODEC_CLOCK_RATIO == agc_tc_pkg::RATIO_6P0) |=>
      (LEFT_DECAY.ms == 16'h5780) && LEFT_DECAY.capped)
  else $error("decay not limited to 22.4 s at ratio 6");

endmodule

// ===== core/agc_tc_pkg.sv
// package: register map, field layout, time tables and carriers for agc time select
package agc_tc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] LEFT_DECAY_OFS = 8'h68;
  localparam logic [7:0] RIGHT_ATTACK_OFS = 8'h69;
  localparam logic [7:0] TIME_REG_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // field positions inside each time register
  localparam int SEL_POS = 7;
  localparam int BASE_LSB = 5;
  localparam int MULT_LSB = 2;
  localparam int RSVD_LSB = 0;

  // ---------------------------------------------------------------
  // times, all in milliseconds
  // ---------------------------------------------------------------
  localparam int TIME_W = 16;
  // decay baseline 50 / 150 / 250 / 350 ms
  localparam logic [15:0] DECAY_BASE0_MS = 16'h0032;
  localparam logic [15:0] DECAY_BASE1_MS = 16'h0096;
  localparam logic [15:0] DECAY_BASE2_MS = 16'h00fa;
  localparam logic [15:0] DECAY_BASE3_MS = 16'h015e;
  // attack baseline 7 / 8 / 10 / 11 ms
  localparam logic [15:0] ATTACK_BASE0_MS = 16'h0007;
  localparam logic [15:0] ATTACK_BASE1_MS = 16'h0008;
  localparam logic [15:0] ATTACK_BASE2_MS = 16'h000a;
  localparam logic [15:0] ATTACK_BASE3_MS = 16'h000b;
  // decay ceilings 4 / 5.6 / 8 / 9.6 / 11.2 / 16 / 19.2 / 22.4 s
  localparam logic [15:0] CAP_4S0_MS = 16'h0fa0;
  localparam logic [15:0] CAP_5S6_MS = 16'h15e0;
  localparam logic [15:0] CAP_8S0_MS = 16'h1f40;
  localparam logic [15:0] CAP_9S6_MS = 16'h2580;
  localparam logic [15:0] CAP_11S2_MS = 16'h2bc0;
  localparam logic [15:0] CAP_16S0_MS = 16'h3e80;
  localparam logic [15:0] CAP_19S2_MS = 16'h4b00;
  localparam logic [15:0] CAP_22S4_MS = 16'h5780;

  // codec clock ratio is carried in half steps: code = 2 * ratio
  localparam logic [3:0] RATIO_1P0 = 4'h2;
  localparam logic [3:0] RATIO_1P5 = 4'h3;
  localparam logic [3:0] RATIO_2P0 = 4'h4;
  localparam logic [3:0] RATIO_2P5 = 4'h5;
  localparam logic [3:0] RATIO_3P0 = 4'h6;
  localparam logic [3:0] RATIO_3P5 = 4'h7;
  localparam logic [3:0] RATIO_4P0 = 4'h8;
  localparam logic [3:0] RATIO_4P5 = 4'h9;
  localparam logic [3:0] RATIO_5P0 = 4'ha;
  localparam logic [3:0] RATIO_5P5 = 4'hb;
  localparam logic [3:0] RATIO_6P0 = 4'hc;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic [1:0] base;
    logic [2:0] mult;
    logic [1:0] rsvd;
  } time_reg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] ms;
    logic from_override;
    logic capped;
  } agc_time_t;

  // ---------------------------------------------------------------
  // lookups
  // ---------------------------------------------------------------
  function automatic logic [15:0] decay_base(input logic [1:0] code);
    unique case (code)
      2'h0: decay_base = DECAY_BASE0_MS;
      2'h1: decay_base = DECAY_BASE1_MS;
      2'h2: decay_base = DECAY_BASE2_MS;
      2'h3: decay_base = DECAY_BASE3_MS;
    endcase
  endfunction

  function automatic logic [15:0] attack_base(input logic [1:0] code);
    unique case (code)
      2'h0: attack_base = ATTACK_BASE0_MS;
      2'h1: attack_base = ATTACK_BASE1_MS;
      2'h2: attack_base = ATTACK_BASE2_MS;
      2'h3: attack_base = ATTACK_BASE3_MS;
    endcase
  endfunction

  // ratios below 1 clamp to the lowest ceiling, above 6 to the highest
  function automatic logic [15:0] decay_cap(input logic [3:0] ratio);
    if (ratio <= RATIO_1P0)
      decay_cap = CAP_4S0_MS;
    else if (ratio == RATIO_1P5)
      decay_cap = CAP_5S6_MS;
    else if (ratio == RATIO_2P0)
      decay_cap = CAP_8S0_MS;
    else if (ratio == RATIO_2P5)
      decay_cap = CAP_9S6_MS;
    else if (ratio == RATIO_3P0 || ratio == RATIO_3P5)
      decay_cap = CAP_11S2_MS;
    else if (ratio == RATIO_4P0 || ratio == RATIO_4P5)
      decay_cap = CAP_16S0_MS;
    else if (ratio == RATIO_5P0)
      decay_cap = CAP_19S2_MS;
    else
      decay_cap = CAP_22S4_MS;
  endfunction

endpackage

// ===== core/agc_time_scale.sv
// one agc time channel: baseline times power-of-two factor, optional ceiling, source select
module agc_time_scale
(
  // register fields
  input wire agc_tc_pkg::time_reg_t field,
  input wire logic [15:0] base_ms,
  // legacy source and ceiling
  input wire logic [15:0] legacy_ms,
  input wire logic cap_en,
  input wire logic [15:0] cap_ms,
  // result
  output agc_tc_pkg::agc_time_t result
);

  wire logic [15:0] scaled_ms;
  wire logic over_cap;
  wire logic [15:0] limited_ms;

  // 350 ms times 128 still fits sixteen bits, so the shift never overflows
  assign scaled_ms = base_ms << field.mult;
  assign over_cap = cap_en && (scaled_ms > cap_ms);
  assign limited_ms = over_cap ? cap_ms : scaled_ms;

  assign result.ms = field.sel ? limited_ms : legacy_ms;
  assign result.from_override = field.sel;
  assign result.capped = field.sel && over_cap;

endmodule

// ===== bench/tb_top.sv
// self-checking testbench for the agc time constant register bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  logic clk;
  logic rst_b;
  logic ce;
  agc_tc_pkg::reg_req_t req;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [3:0] ratio;
  logic [15:0] leg_l;
  logic [15:0] leg_r;
  agc_tc_pkg::agc_time_t left;
  agc_tc_pkg::agc_time_t right;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  // expected tables in ms, kept apart from the design's own lookups
  int dbase[4] = '{50, 150, 250, 350};
  int abase[4] = '{7, 8, 10, 11};
  // ceiling by ratio code (two per unit); codes below 2 and above 12 clamp to the ends
  int cap_tab[16] = '{4000, 4000, 4000, 5600, 8000, 9600, 11200, 11200,
                      16000, 16000, 19200, 22400, 22400, 22400, 22400, 22400};

  agc_time_select i_dut
  (
    .CLK(clk),
    .RST_B(rst_b),
    .CE(ce),
    .REG_REQ(req),
    .REG_RD_DATA(rd_data),
    .REG_RD_VALID(rd_valid),
    .CODEC_CLOCK_RATIO(ratio),
    .LEGACY_LEFT_DECAY_MS(leg_l),
    .LEGACY_RIGHT_ATTACK_MS(leg_r),
    .LEFT_DECAY(left),
    .RIGHT_ATTACK(right)
  );

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_total++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    req = '{1'b1, 1'b0, addr, data};
    @(posedge clk);
    #1;
    req = '0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    #1;
    req = '{1'b0, 1'b1, addr, 8'h00};
    @(posedge clk);
    #1;
    req = '0;
    chk(rd_valid, 1'b1);
    chk(rd_data, exp);
    @(posedge clk);
    #1;
    chk(rd_valid, 1'b0);
  endtask

  // one extra edge beyond the one-cycle update, outputs are levels
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(left, 18'h00000);
    chk(right, 18'h00000);
    rst_b = 1'b1;
    rd_chk(8'h68, 8'h00);
    rd_chk(8'h69, 8'h00);
    chk(left, {leg_l, 2'b00});
    chk(right, {leg_r, 2'b00});
  endtask

  task automatic t_decay_table();
    int raw;
    ratio = 4'hc;
    for (int b = 0; b < 4; b++)
      for (int m = 0; m < 8; m++)
      begin
        raw = dbase[b] << m;
        wr(8'h68, {1'b1, b[1:0], m[2:0], 2'b00});
        settle();
        chk(left.ms, (raw > 22400) ? 22400 : raw);
        chk(left.from_override, 1'b1);
        // a product equal to the ceiling is not a cut, so the flag stays low
        chk(left.capped, raw > 22400);
      end
  endtask

  task automatic t_caps();
    wr(8'h68, 8'hfc);
    for (int r = 0; r < 16; r++)
    begin
      ratio = r[3:0];
      settle();
      chk(left.ms, cap_tab[r]);
      chk(left.capped, 1'b1);
    end
  endtask

  task automatic t_attack_table();
    ratio = 4'h2;
    for (int b = 0; b < 4; b++)
      for (int m = 0; m < 8; m++)
      begin
        wr(8'h69, {1'b1, b[1:0], m[2:0], 2'b00});
        settle();
        chk(right, {abase[b][15:0] << m, 2'b10});
      end
  endtask

  task automatic t_legacy();
    ratio = 4'h2;
    wr(8'h68, 8'h7c);
    wr(8'h69, 8'h7c);
    leg_l = 16'h1234;
    leg_r = 16'h0abc;
    settle();
    chk(left, {16'h1234, 2'b00});
    chk(right, {16'h0abc, 2'b00});
  endtask

  task automatic t_regs();
    wr(8'h68, 8'ha8);
    wr(8'h69, 8'h54);
    rd_chk(8'h68, 8'ha8);
    rd_chk(8'h69, 8'h54);
    rd_chk(8'h6a, 8'h00);
    // read and write together: the read returns what was held before the write
    @(posedge clk);
    #1;
    req = '{1'b1, 1'b1, 8'h69, 8'h00};
    @(posedge clk);
    #1;
    req = '0;
    chk(rd_valid, 1'b1);
    chk(rd_data, 8'h54);
    rd_chk(8'h69, 8'h00);
    ce = 1'b0;
    wr(8'h68, 8'h00);
    ce = 1'b1;
    rd_chk(8'h68, 8'ha8);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    ce = 1'b1;
    req = '0;
    ratio = 4'h2;
    leg_l = 16'h00c8;
    leg_r = 16'h0014;
    t_reset();
    t_decay_table();
    t_caps();
    t_attack_table();
    t_legacy();
    t_regs();
    // second reset with the override selected proves the bits clear
    t_reset();
    wrap_up();
  end
endmodule
